// ### access_fault_check.v
// exception selection for one instruction, by mode and access state
// assumes decoded instruction class and access bits are stable
`timescale 1ns/1ps
`include "double_shift_flag_exec_regs.vh"
module access_fault_check (
  input  wire [1:0] mode,
  input  wire [1:0] current_privilege_level,
  input  wire [1:0] io_privilege_level,
  input  wire       known_op,
  input  wire       stores,
  input  wire       mem_dest,
  input  wire       is_ldt,
  input  wire       is_set_ie,
  input  wire [5:0] access,
  output reg        fault,
  output reg  [7:0] vector
);
  wire prot;
  wire v86;
  wire user;

  assign prot = (mode == `MODE_PROT);
  assign v86  = (mode == `MODE_V86);
  assign user = (current_privilege_level == 2'h3);

  ////////////////////////////////////////////////////////////////////
  // first matching cause wins; invalid opcode precedes memory checks
  always @* begin
    fault  = 1'b1;
    vector = `VEC_NONE;
    if (~known_op | (is_ldt & ~prot)) begin
      vector = `VEC_INVALID;
    end else if (stores & mem_dest & prot) begin
      if (access[`ACC_NONWR] | access[`ACC_BAD_EA])
        vector = `VEC_GENPROT;
      else if (access[`ACC_BAD_SS])
        vector = `VEC_STACK;
      else if (access[`ACC_PAGE_MISS])
        vector = `VEC_PAGE;
      else if (access[`ACC_UNALIGNED] & user)
        vector = `VEC_ALIGN;
      else
        fault = 1'b0;
    end else if (stores & mem_dest) begin
      if (access[`ACC_BEYOND])
        vector = `VEC_GENPROT;
      else if (v86 & access[`ACC_PAGE_MISS])
        vector = `VEC_PAGE;
      else if (v86 & access[`ACC_UNALIGNED] & user)
        vector = `VEC_ALIGN;
      else
        fault = 1'b0;
    end else if (is_set_ie & prot & (current_privilege_level > io_privilege_level)) begin
      vector = `VEC_GENPROT;
    end else begin
      fault = 1'b0;
    end
  end
endmodule

// ### double_shift_flag_exec.v
// execution slice: double right shift, selector and status stores,
// carry, direction and interrupt-enable set with interrupt shadow
// assumes an Avalon-MM master on mclk; operands are loaded by software
`timescale 1ns/1ps
`include "double_shift_flag_exec_regs.vh"
module double_shift_flag_exec (
  input  wire        mclk,
  input  wire        reset,
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  output wire        int_recognisable,
  output wire        string_decrement
);
  reg         ack;
  reg  [19:0] op_ctrl;
  reg  [31:0] dest_in;
  reg  [31:0] src_in;
  reg  [15:0] count_in;
  reg  [5:0]  access_in;
  reg  [15:0] ldt_sel;
  reg  [15:0] machine_status_word;
  reg  [31:0] result;
  reg         cf;
  reg         pf;
  reg         af;
  reg         zf;
  reg         sf;
  reg         if_f;
  reg         df;
  reg         of;
  reg         busy;
  reg         done;
  reg         fault;
  reg  [7:0]  vector;
  reg  [5:0]  undef;
  reg         dest_written;
  reg         shadow;
  reg  [2:0]  cnt;
  reg  [2:0]  need;
  reg  [31:0] next_read;
  wire        req;
  wire        wr_take;
  wire [31:0] be_mask;
  wire [31:0] wr_status;
  wire [31:0] flag_word;
  wire [7:0]  opcode;
  wire        two_byte;
  wire [2:0]  reg_field;
  wire        mem_dest;
  wire        size32;
  wire [1:0]  mode;
  wire [1:0]  current_privilege_level;
  wire [1:0]  io_privilege_level;
  wire        is_shift_imm;
  wire        is_shift_cnt;
  wire        is_shift;
  wire        is_ldt;
  wire        is_msw;
  wire        is_set_carry;
  wire        is_set_dir;
  wire        is_set_ie;
  wire        is_clr_ie;
  wire        known_op;
  wire        stores;
  wire [4:0]  amt;
  wire [31:0] sh_result;
  wire        sh_cf;
  wire        sh_of;
  wire        sh_sf;
  wire        sh_zf;
  wire        sh_pf;
  wire        sh_bad;
  wire        sh_noop;
  wire        f_fault;
  wire [7:0]  f_vector;

  ////////////////////////////////////////////////////////////////////
  // bus handshake: every access waits exactly one cycle, then completes
  assign req         = read | write;
  assign waitrequest = req & ~ack;
  assign wr_take     = write & ack;
  assign be_mask     = {{8{byteenable[3]}}, {8{byteenable[2]}},
                        {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wr_status   = writedata & be_mask;

  // decoded fields of the latched instruction
  assign opcode    = op_ctrl[`OPC_BYTE_HI:0];
  assign two_byte  = op_ctrl[`OPC_TWO_BYTE];
  assign reg_field = op_ctrl[`OPC_REG_LO+2:`OPC_REG_LO];
  assign mem_dest  = op_ctrl[`OPC_MEM_DEST];
  assign size32    = op_ctrl[`OPC_SIZE32];
  assign mode      = op_ctrl[`OPC_MODE_LO+1:`OPC_MODE_LO];
  assign current_privilege_level       = op_ctrl[`OPC_CPL_LO+1:`OPC_CPL_LO];
  assign io_privilege_level      = op_ctrl[`OPC_IO_PRIVILEGE_LEVEL_LO+1:`OPC_IO_PRIVILEGE_LEVEL_LO];

  ////////////////////////////////////////////////////////////////////
  // instruction classes
  assign is_shift_imm = two_byte & (opcode == `OP_SHIFT_IMM);
  assign is_shift_cnt = two_byte & (opcode == `OP_SHIFT_CNT);
  assign is_shift     = is_shift_imm | is_shift_cnt;
  assign is_ldt       = two_byte & (opcode == `OP_GRP_LDT)
                        & (reg_field == `REG_LDT);
  assign is_msw       = two_byte & (opcode == `OP_GRP_MSW)
                        & (reg_field == `REG_MSW);
  assign is_set_carry = ~two_byte & (opcode == `OP_SET_CARRY);
  assign is_set_dir   = ~two_byte & (opcode == `OP_SET_DIR);
  assign is_set_ie    = ~two_byte & (opcode == `OP_SET_IE);
  assign is_clr_ie    = ~two_byte & (opcode == `OP_CLR_IE);
  assign known_op     = is_shift | is_ldt | is_msw | is_set_carry
                        | is_set_dir | is_set_ie | is_clr_ie;
  assign stores       = is_shift | is_ldt | is_msw;

  // count source by opcode; only five bits survive, i.e. modulo 32
  assign amt = is_shift_cnt ? count_in[12:8] : count_in[4:0];

  ////////////////////////////////////////////////////////////////////
  // clocks per instruction form
  always @* begin
    need = `CLK_SET_FLAG;
    if (is_shift_imm)
      need = mem_dest ? `CLK_SHIFT_IMM_MEM : `CLK_SHIFT_IMM_REG;
    else if (is_shift_cnt)
      need = mem_dest ? `CLK_SHIFT_CNT_MEM : `CLK_SHIFT_CNT_REG;
    else if (is_ldt | is_msw)
      need = mem_dest ? `CLK_STORE_MEM : `CLK_STORE_REG;
    else if (is_set_ie)
      need = `CLK_SET_IE;
    else if (is_clr_ie)
      need = `CLK_CLR_IE;
    else
      need = `CLK_SET_FLAG;
  end

  double_shift_unit u_shift (
    .dest    (dest_in),
    .src     (src_in),
    .amt     (amt),
    .size32  (size32),
    .result  (sh_result),
    .carry   (sh_cf),
    .ovf     (sh_of),
    .sign    (sh_sf),
    .zero    (sh_zf),
    .parity  (sh_pf),
    .bad_amt (sh_bad),
    .no_op   (sh_noop)
  );

  access_fault_check u_fault (
    .mode      (mode),
    .current_privilege_level       (current_privilege_level),
    .io_privilege_level      (io_privilege_level),
    .known_op  (known_op),
    .stores    (stores),
    .mem_dest  (mem_dest),
    .is_ldt    (is_ldt),
    .is_set_ie (is_set_ie),
    .access    (access_in),
    .fault     (f_fault),
    .vector    (f_vector)
  );

  ////////////////////////////////////////////////////////////////////
  // flags image and read mux
  assign flag_word = {20'h00000, of, df, if_f, 1'b0, sf, zf, 1'b0,
                      af, 1'b0, pf, 1'b0, cf};

  always @* begin
    case (address[5:2])
      4'h0:    next_read = {12'h000, op_ctrl};
      4'h1:    next_read = dest_in;
      4'h2:    next_read = src_in;
      4'h3:    next_read = {16'h0000, count_in};
      4'h4:    next_read = {26'h0000000, access_in};
      4'h5:    next_read = {machine_status_word, ldt_sel};
      4'h6:    next_read = result;
      4'h7:    next_read = flag_word;
      4'h8:    next_read = {9'h000, dest_written, undef, vector,
                            3'h0, shadow, int_recognisable, fault,
                            done, busy};
      default: next_read = 32'h00000000;
    endcase
  end

  // interrupts wait out one whole instruction after the enable
  assign int_recognisable = if_f & ~shadow;
  assign string_decrement = df;

  ////////////////////////////////////////////////////////////////////
  // register file and execution sequencer; writes that touch operands
  // are refused while busy so the running instruction sees stable data
  always @(posedge mclk) begin
    if (reset) begin
      ack          <= 1'b0;
      readdata     <= 32'h00000000;
      op_ctrl      <= `OP_CTRL_RESET;
      dest_in      <= 32'h00000000;
      src_in       <= 32'h00000000;
      count_in     <= 16'h0000;
      access_in    <= 6'h00;
      ldt_sel      <= 16'h0000;
      machine_status_word          <= 16'h0000;
      result       <= 32'h00000000;
      cf           <= 1'b0;
      pf           <= 1'b0;
      af           <= 1'b0;
      zf           <= 1'b0;
      sf           <= 1'b0;
      if_f         <= 1'b0;
      df           <= 1'b0;
      of           <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      fault        <= 1'b0;
      vector       <= `VEC_NONE;
      undef        <= 6'h00;
      dest_written <= 1'b0;
      shadow       <= 1'b0;
      cnt          <= 3'h0;
    end else begin
      ack <= req & ~ack;
      if (read & ~ack)
        readdata <= next_read;
      if (wr_take & ~busy) begin
        case (address[5:2])
          4'h0: begin
            op_ctrl <= wr_status[19:0];
            busy    <= 1'b1;
            done    <= 1'b0;
            cnt     <= 3'h1;
          end
          4'h1: dest_in   <= (dest_in & ~be_mask) | wr_status;
          4'h2: src_in    <= (src_in & ~be_mask) | wr_status;
          4'h3: count_in  <= (count_in & ~be_mask[15:0]) | wr_status[15:0];
          4'h4: access_in <= wr_status[5:0];
          4'h5: begin
            ldt_sel <= (ldt_sel & ~be_mask[15:0]) | wr_status[15:0];
            machine_status_word     <= (machine_status_word & ~be_mask[31:16]) | wr_status[31:16];
          end
          4'h7: begin
            cf   <= wr_status[`FLG_CF];
            pf   <= wr_status[`FLG_PF];
            af   <= wr_status[`FLG_AF];
            zf   <= wr_status[`FLG_ZF];
            sf   <= wr_status[`FLG_SF];
            if_f <= wr_status[`FLG_IF];
            df   <= wr_status[`FLG_DF];
            of   <= wr_status[`FLG_OF];
          end
          default: ;
        endcase
      end
      if (busy) begin
        if (cnt != need) begin
          cnt <= cnt + 3'h1;
        end else begin
          // retire: shadow ends with the instruction after the enable
          busy         <= 1'b0;
          done         <= 1'b1;
          fault        <= f_fault;
          vector       <= f_vector;
          undef        <= 6'h00;
          dest_written <= 1'b0;
          shadow       <= 1'b0;
          if (f_fault) begin
            // faulting instructions leave every flag and the result alone
          end else if (is_shift) begin
            if (sh_noop) begin
              // nothing written, nothing flagged
            end else if (sh_bad) begin
              undef <= `UND_ALL;
            end else begin
              result       <= sh_result;
              dest_written <= 1'b1;
              cf           <= sh_cf;
              sf           <= sh_sf;
              zf           <= sh_zf;
              pf           <= sh_pf;
              if (amt == 5'h01) begin
                of    <= sh_of;
                undef <= 6'h01 << `UND_AF;
              end else begin
                undef <= (6'h01 << `UND_AF) | (6'h01 << `UND_OF);
              end
            end
          end else if (is_ldt) begin
            result       <= {dest_in[31:16], ldt_sel};
            dest_written <= 1'b1;
          end else if (is_msw) begin
            result       <= {dest_in[31:16], machine_status_word};
            dest_written <= 1'b1;
          end else if (is_set_carry) begin
            cf <= 1'b1;
          end else if (is_set_dir) begin
            df <= 1'b1;
          end else if (is_set_ie) begin
            if_f   <= 1'b1;
            shadow <= 1'b1;
          end else if (is_clr_ie) begin
            if_f <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ### double_shift_flag_exec_regs.vh
// register map, field positions, opcodes, vectors and clock counts
// assumes inclusion by every design file of the execution slice
`ifndef DOUBLE_SHIFT_FLAG_EXEC_REGS_VH
`define DOUBLE_SHIFT_FLAG_EXEC_REGS_VH
// byte offsets on the register bus (word index is address[5:2])
`define REG_OP_CTRL   6'h00
`define REG_DEST_IN   6'h04
`define REG_SRC_IN    6'h08
`define REG_COUNT     6'h0c
`define REG_ACCESS    6'h10
`define REG_SYSREG    6'h14
`define REG_RESULT    6'h18
`define REG_FLAGS     6'h1c
`define REG_STATUS    6'h20
// op_ctrl fields
`define OPC_BYTE_HI   7
`define OPC_TWO_BYTE  8
`define OPC_REG_LO    9
`define OPC_MEM_DEST  12
`define OPC_SIZE32    13
`define OPC_MODE_LO   14
`define OPC_CPL_LO    16
`define OPC_IO_PRIVILEGE_LEVEL_LO   18
`define OP_CTRL_RESET 20'h00000
// operating modes
`define MODE_REAL     2'h0
`define MODE_PROT     2'h1
`define MODE_V86      2'h2
// access condition bits
`define ACC_NONWR     0
`define ACC_BAD_EA    1
`define ACC_BAD_SS    2
`define ACC_PAGE_MISS 3
`define ACC_UNALIGNED 4
`define ACC_BEYOND    5
// flag positions in the flags register
`define FLG_CF        0
`define FLG_PF        2
`define FLG_AF        4
`define FLG_ZF        6
`define FLG_SF        7
`define FLG_IF        9
`define FLG_DF        10
`define FLG_OF        11
// undefined-flag mask bits in status[21:16]
`define UND_CF        0
`define UND_PF        1
`define UND_AF        2
`define UND_ZF        3
`define UND_SF        4
`define UND_OF        5
`define UND_ALL       6'h3f
// opcodes
`define OP_SHIFT_IMM  8'hac
`define OP_SHIFT_CNT  8'had
`define OP_GRP_LDT    8'h00
`define OP_GRP_MSW    8'h01
`define REG_LDT       3'h0
`define REG_MSW       3'h4
`define OP_SET_CARRY  8'hf9
`define OP_SET_DIR    8'hfd
`define OP_SET_IE     8'hfb
`define OP_CLR_IE     8'hfa
// exception vectors
`define VEC_NONE      8'h00
`define VEC_INVALID   8'h06
`define VEC_STACK     8'h0c
`define VEC_GENPROT   8'h0d
`define VEC_PAGE      8'h0e
`define VEC_ALIGN     8'h11
// execution clock counts
`define CLK_SHIFT_IMM_REG 3'd2
`define CLK_SHIFT_IMM_MEM 3'd3
`define CLK_SHIFT_CNT_REG 3'd3
`define CLK_SHIFT_CNT_MEM 3'd4
`define CLK_STORE_REG     3'd2
`define CLK_STORE_MEM     3'd3
`define CLK_SET_FLAG      3'd2
`define CLK_SET_IE        3'd5
`define CLK_CLR_IE        3'd5
`endif

// ### double_shift_unit.v
// combinational double-precision right shift with its result flags
// assumes operands and count are held stable by the caller
`timescale 1ns/1ps
`include "double_shift_flag_exec_regs.vh"
module double_shift_unit (
  input  wire [31:0] dest,
  input  wire [31:0] src,
  input  wire [4:0]  amt,
  input  wire        size32,
  output wire [31:0] result,
  output wire        carry,
  output wire        ovf,
  output wire        sign,
  output wire        zero,
  output wire        parity,
  output wire        bad_amt,
  output wire        no_op
);
  wire [63:0] pair32;
  wire [63:0] pair16;
  wire [63:0] wide;
  wire [31:0] shifted;
  wire        msb_new;
  wire        msb_old;

  ////////////////////////////////////////////////////////////////////
  // fill enters from the top, second operand's low bits first
  assign pair32  = {src, dest};
  assign pair16  = {32'h00000000, src[15:0], dest[15:0]};
  assign wide    = (size32 ? pair32 : pair16) >> amt;
  assign shifted = wide[31:0];
  assign result  = size32 ? shifted : {16'h0000, shifted[15:0]};
  // amt is already modulo 32, so width 32 never counts as bad
  assign bad_amt = ~size32 & amt[4];
  assign no_op   = (amt == 5'h00);
  // last bit out is original bit amt-1
  assign carry   = dest[amt - 5'h01];
  assign msb_new = size32 ? result[31] : result[15];
  assign msb_old = size32 ? dest[31] : dest[15];
  assign ovf     = msb_new ^ msb_old;
  assign sign    = msb_new;
  assign zero    = (result == 32'h00000000);
  // parity looks at the low byte only, even count sets it
  assign parity  = ~^result[7:0];
endmodule

// ### exec_slice_monitor.sv
// checker for the execution slice, fed from its top-level ports only
// assumes the single clock mclk and a synchronous active-high reset
`timescale 1ns/1ps
module exec_slice_monitor (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        int_recognisable,
  input wire logic        string_decrement
);
  int unsigned since_wr;
  // cycles since the last accepted write; flag pins may only move soon after one
  always_ff @(posedge mclk) begin
    if (reset) since_wr <= 100;
    else if (write && !waitrequest) since_wr <= 0;
    else if (since_wr < 100) since_wr <= since_wr + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_req_rise; $rose(read || write); endsequence
  sequence s_ack; (read || write) && !waitrequest; endsequence
  ////////////////////////////////////////
  a_wait_first: assert property (s_req_rise |-> waitrequest)
    else $error("no wait state on a new request");
  a_wait_one: assert property ((read || write) && waitrequest |=> s_ack)
    else $error("request not answered after one wait");
  a_idle_quiet: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without a request");
  a_reset_clear: assert property ($fell(reset) |-> !int_recognisable && !string_decrement)
    else $error("flag pins set after reset");
  a_rdata_hold: assert property (!$past(read) |-> $stable(readdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (read && !waitrequest && address[5:2] > 4'h8 |-> readdata == 0)
    else $error("unmapped read not zero");
  a_dir_cause: assert property ($changed(string_decrement) |-> since_wr <= 6)
    else $error("direction moved without an instruction");
  a_int_cause: assert property ($changed(int_recognisable) |-> since_wr <= 7)
    else $error("interrupt enable moved without an instruction");
endmodule
bind double_shift_flag_exec exec_slice_monitor mon (.mclk(mclk), .reset(reset),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .int_recognisable(int_recognisable), .string_decrement(string_decrement));

// ### operand_feeder.sv
// decode and operand-fetch side, modelled as the bus master of the slice
// assumes one bench process at a time calls its transfer task
`timescale 1ns/1ps
module operand_feeder (
  input  wire logic        mclk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
  end
  // one transfer; launched after an edge so back-to-back calls leave an idle
  // cycle, and held until the edge at which waitrequest is seen low
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= ~rw;
    write <= rw;
    forever begin
      @(posedge mclk);
      if (!waitrequest) begin
        q = readdata;
        break;
      end
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// ### tb.sv
// self-checking bench for the execution slice
// assumes the feeder model as bus master and the bound port checker
`timescale 1ns/1ps
`include "double_shift_flag_exec_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h want %h", $time, (g), (e)); end end
module tb;
  logic        mclk;
  logic        reset;
  wire  [5:0]  address;
  wire         read;
  wire         write;
  wire  [31:0] writedata;
  wire  [3:0]  byteenable;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire         int_recognisable;
  wire         string_decrement;
  int          err_total = 0;
  int          checked = 0;
  logic [31:0] q;
  logic [31:0] st;
  double_shift_flag_exec dut (.mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .int_recognisable(int_recognisable),
    .string_decrement(string_decrement));
  operand_feeder feeder (.mclk(mclk), .readdata(readdata), .waitrequest(waitrequest),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task wr(input logic [5:0] a, input logic [31:0] d); feeder.xfer(1'b1, a, d, q); endtask
  task rd(input logic [5:0] a); feeder.xfer(1'b0, a, 32'h0, q); endtask
  function automatic logic [19:0] opc(input logic [8:0] code, input logic [2:0] rg,
    input logic mem, sz, input logic [1:0] md, current_privilege_level, io_privilege_level);
    return {io_privilege_level, current_privilege_level, md, sz, mem, rg, code};
  endfunction
  // start one instruction; busy must stand at least n and at most n+2 clocks
  task exec(input logic [19:0] op, input int n);
    wr(`REG_OP_CTRL, {12'h000, op});
    repeat (n - 2) @(posedge mclk);
    rd(`REG_STATUS);
    `CHK(q[0], 1'b1)
    rd(`REG_STATUS);
    `CHK(q[1:0], 2'b10)
    st = q;
  endtask
  // one double shift, expectation built from a 64-bit concatenation
  task shift(input logic cf, mem, sz, input logic [31:0] d, s, input logic [7:0] c);
    logic [4:0]  a;
    logic [63:0] w;
    logic [31:0] r;
    a = c[4:0];
    w = sz ? {s, d} : {32'h0, s[15:0], d[15:0]};
    w = w >> a;
    r = sz ? w[31:0] : {16'h0, w[15:0]};
    wr(`REG_FLAGS, 32'h0);
    wr(`REG_DEST_IN, d);
    wr(`REG_SRC_IN, s);
    wr(`REG_COUNT, cf ? {16'h0, c, ~c} : {16'h0, ~c, c});
    exec(opc(cf ? 9'h1ad : 9'h1ac, 3'h0, mem, sz, `MODE_PROT, 2'h0, 2'h0),
         cf ? (mem ? 4 : 3) : (mem ? 3 : 2));
    rd(`REG_RESULT);
    if (a == 0 || a >= (sz ? 32 : 16)) begin
      `CHK(st[22], 1'b0)
      `CHK(st[21:16], (a == 0) ? 6'h00 : `UND_ALL)
      rd(`REG_FLAGS);
      `CHK(q[11:0], 12'h000)
    end else begin
      `CHK(q, r)
      rd(`REG_FLAGS);
      `CHK({q[0], q[2], q[6], q[7]}, {d[a-1], ~^r[7:0], r == 0, sz ? r[31] : r[15]})
      if (a == 1) `CHK(q[11], sz ? r[31] ^ d[31] : r[15] ^ d[15])
    end
    rd(`REG_SRC_IN);
    `CHK(q, s)
  endtask
  // one instruction with an access condition and its expected vector
  task fault(input logic [19:0] op, input logic [5:0] acc, input int n, input logic [7:0] v);
    wr(`REG_ACCESS, {26'h0, acc});
    exec(op, n);
    `CHK({st[2], st[15:8]}, {v != 8'h00, v})
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  // hang guard: far beyond the few hundred cycles the sequence needs
  initial begin
    #3000000;
    err_total++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    shift(0, 0, 1, 32'h8000_0001, 32'h0000_0003, 8'h01);
    shift(1, 1, 1, 32'h1234_5678, 32'hffff_0000, 8'h3f);
    shift(0, 1, 0, 32'h0000_8421, 32'h0000_00a5, 8'h05);
    shift(1, 0, 0, 32'h0000_0001, 32'h0000_0000, 8'h21);
    shift(0, 0, 1, 32'h0f0f_0f0f, 32'h1111_1111, 8'h40);
    shift(1, 0, 0, 32'h0000_0f0f, 32'h0000_1111, 8'h14);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_PROT, 0, 0), 6'h01, 3, `VEC_GENPROT);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_PROT, 0, 0), 6'h02, 3, `VEC_GENPROT);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_PROT, 0, 0), 6'h04, 3, `VEC_STACK);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_PROT, 0, 0), 6'h08, 3, `VEC_PAGE);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_PROT, 3, 0), 6'h10, 3, `VEC_ALIGN);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_PROT, 0, 0), 6'h10, 3, `VEC_NONE);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_REAL, 0, 0), 6'h20, 3, `VEC_GENPROT);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_V86, 0, 0), 6'h08, 3, `VEC_PAGE);
    fault(opc(9'h1ac, 0, 1, 1, `MODE_V86, 3, 0), 6'h10, 3, `VEC_ALIGN);
    fault(opc(9'h0aa, 0, 0, 0, `MODE_PROT, 0, 0), 6'h00, 2, `VEC_INVALID);
    fault(opc(9'h100, 0, 0, 0, `MODE_REAL, 0, 0), 6'h00, 2, `VEC_INVALID);
    fault(opc(9'h100, 0, 0, 0, `MODE_V86, 0, 0), 6'h00, 2, `VEC_INVALID);
    fault(opc(9'h101, 4, 0, 0, `MODE_REAL, 0, 0), 6'h00, 2, `VEC_NONE);
    fault(opc(9'h0fb, 0, 0, 0, `MODE_PROT, 3, 0), 6'h00, 5, `VEC_GENPROT);
    fault(opc(9'h0fb, 0, 0, 0, `MODE_PROT, 0, 3), 6'h00, 5, `VEC_NONE);
    fault(opc(9'h0fb, 0, 0, 0, `MODE_REAL, 3, 0), 6'h00, 5, `VEC_NONE);
    store_check();
    flag_set_check();
    ie_shadow_check();
    map_check();
    complete_run();
  end
  // selector and status stores copy their source and leave flags alone
  task store_check;
    wr(`REG_ACCESS, 32'h0);
    wr(`REG_SYSREG, 32'hbeef_1234);
    wr(`REG_FLAGS, 32'h0000_08d5);
    exec(opc(9'h100, 0, 0, 1, `MODE_PROT, 0, 0), 2);
    rd(`REG_RESULT);
    `CHK(q[15:0], 16'h1234)
    exec(opc(9'h101, 4, 1, 0, `MODE_REAL, 0, 0), 3);
    rd(`REG_RESULT);
    `CHK(q[15:0], 16'hbeef)
    rd(`REG_FLAGS);
    `CHK(q[11:0], 12'h8d5)
  endtask
  // carry and direction sets touch only their own bits
  task flag_set_check;
    wr(`REG_FLAGS, 32'h0);
    exec(opc(9'h0f9, 0, 0, 0, `MODE_PROT, 3, 0), 2);
    exec(opc(9'h0fd, 0, 0, 0, `MODE_PROT, 3, 0), 2);
    rd(`REG_FLAGS);
    `CHK({string_decrement, q[11:0]}, 13'h1401)
  endtask
  // enable waits out one instruction; a clear right after leaves no window
  task ie_shadow_check;
    exec(opc(9'h0fb, 0, 0, 0, `MODE_REAL, 0, 0), 5);
    `CHK(int_recognisable, 1'b0)
    exec(opc(9'h0f9, 0, 0, 0, `MODE_REAL, 0, 0), 2);
    `CHK(int_recognisable, 1'b1)
    exec(opc(9'h0fa, 0, 0, 0, `MODE_REAL, 0, 0), 5);
    exec(opc(9'h0fb, 0, 0, 0, `MODE_REAL, 0, 0), 5);
    exec(opc(9'h0fa, 0, 0, 0, `MODE_REAL, 0, 0), 5);
    rd(`REG_FLAGS);
    `CHK({int_recognisable, q[9], q[10]}, 3'b001)
  endtask
  // unmapped reads give zero and the result register ignores writes
  task map_check;
    rd(6'h3c);
    `CHK(q, 32'h0)
    wr(`REG_RESULT, 32'hffff_ffff);
    rd(`REG_RESULT);
    `CHK(q[15:0], 16'hbeef)
  endtask
endmodule
